// ### hw/interrupt_priority_fields.sv
// Contract
// - each source has a 3-bit priority, 1..7, all-ones highest
// - priority code zero disables the source; its request is never forwarded
// - bits holding no field ignore writes and read zero
// - every field is read/write and resets to binary 100
// - pin change priority at bits 14..12 of register 4
// - comparator priority at bits 10..8 of register 4
// - i2c master event priority at bits 6..4 of register 4
// - i2c slave event priority at bits 2..0 of register 4
// - external irq one priority at bits 2..0 of register 5, rest unused
// - serial b transmit priority at bits 14..12 of register 7
// - serial b receive priority at bits 10..8 of register 7
// - external irq two priority at bits 6..4 of register 7, 3..0 unused
// - calendar priority at bits 10..8 of register 15, rest read zero
// - checksum error priority at bits 14..12 of register 16
// - serial b error priority at bits 10..8 of register 16
// - serial a error priority at bits 6..4 of register 16, 3..0 unused
// - voltage detect priority at bits 2..0 of register 18, rest unused
// - charge timer priority at bits 6..4 of register 19, rest read zero
// - after reset every source sits at priority level 4
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
module interrupt_priority_fields
(
   input wire logic clk,
   input wire logic srst,
   input wire prio_fields_pkg::reg_req_t req,
   output logic [prio_fields_pkg::DATA_W-1:0] rdata,
   input wire logic [prio_fields_pkg::NUM_SRC-1:0] src_req,
   output prio_fields_pkg::prio_set_t prio,
   output logic [prio_fields_pkg::NUM_SRC-1:0] src_fwd
);
   import prio_fields_pkg::*;

   // ----------------------------------------------------------------
   // field storage
   // ----------------------------------------------------------------
   // gathers the field flops below; it holds no state of its own
   prio_set_t prio_r;

   // register 4 fields
   logic [PRIO_W-1:0] pin_change_r;
   logic [PRIO_W-1:0] comparator_r;
   logic [PRIO_W-1:0] i2c_master_r;
   logic [PRIO_W-1:0] i2c_slave_r;

   // register 5 field
   logic [PRIO_W-1:0] ext_irq_one_r;

   // register 7 fields
   logic [PRIO_W-1:0] serial_b_tx_r;
   logic [PRIO_W-1:0] serial_b_rx_r;
   logic [PRIO_W-1:0] ext_irq_two_r;

   // register 15 field
   logic [PRIO_W-1:0] calendar_r;

   // register 16 fields
   logic [PRIO_W-1:0] checksum_error_r;
   logic [PRIO_W-1:0] serial_b_error_r;
   logic [PRIO_W-1:0] serial_a_error_r;

   // register 18 field
   logic [PRIO_W-1:0] voltage_detect_r;

   // register 19 field
   logic [PRIO_W-1:0] charge_timer_r;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // the layout is fixed at up to four 3-bit slots per 16-bit word
   if (PRIO_W != 3)
   begin : g_chk_prio_w
      $error("priority field width must be 3");
   end
   if (DATA_W != 16)
   begin : g_chk_data_w
      $error("register word width must be 16");
   end
   if (NUM_SRC * PRIO_W != $bits(prio_set_t))
   begin : g_chk_set
      $error("source count does not match the priority set");
   end
   if (POS_HI + PRIO_W > DATA_W)
   begin : g_chk_top
      $error("top field does not fit the register word");
   end
   if (POS_BOT + PRIO_W > POS_LO || POS_LO + PRIO_W > POS_MID || POS_MID + PRIO_W > POS_HI)
   begin : g_chk_overlap
      $error("field slots overlap");
   end
   if (PRIO_TOP != {PRIO_W{1'b1}})
   begin : g_chk_top_code
      $error("highest priority must be the all-ones code");
   end
   if (PRIO_RESET == PRIO_OFF)
   begin : g_chk_reset
      $error("reset priority must not disable the sources");
   end

   function automatic logic [PRIO_W-1:0] fld(input logic [DATA_W-1:0] d, input int pos);
      fld = d[pos +: PRIO_W];
   endfunction : fld

   function automatic logic [DATA_W-1:0] place(input logic [PRIO_W-1:0] v, input int pos);
      logic [DATA_W-1:0] w;
      w = '0;
      w[pos +: PRIO_W] = v;
      place = w;
   endfunction : place

   // ----------------------------------------------------------------
   // write side: one flop group per register
   // ----------------------------------------------------------------
   // writes to other indexes match no block and bits outside fields have no flops
   function automatic logic wr_hit(input reg_req_t r, input logic [ADDR_W-1:0] ofs);
      wr_hit = r.wr && (r.addr == ofs);
   endfunction : wr_hit

   // register 4
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pin_change_r <= PRIO_RESET;
         comparator_r <= PRIO_RESET;
         i2c_master_r <= PRIO_RESET;
         i2c_slave_r <= PRIO_RESET;
      end
      else if (wr_hit(req, OFS_PRIO_CTRL_4))
      begin
         pin_change_r <= fld(req.wdata, POS_HI);
         comparator_r <= fld(req.wdata, POS_MID);
         i2c_master_r <= fld(req.wdata, POS_LO);
         i2c_slave_r <= fld(req.wdata, POS_BOT);
      end
   end

   // register 5
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ext_irq_one_r <= PRIO_RESET;
      end
      else if (wr_hit(req, OFS_PRIO_CTRL_5))
      begin
         ext_irq_one_r <= fld(req.wdata, POS_BOT);
      end
   end

   // register 7
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         serial_b_tx_r <= PRIO_RESET;
         serial_b_rx_r <= PRIO_RESET;
         ext_irq_two_r <= PRIO_RESET;
      end
      else if (wr_hit(req, OFS_PRIO_CTRL_7))
      begin
         serial_b_tx_r <= fld(req.wdata, POS_HI);
         serial_b_rx_r <= fld(req.wdata, POS_MID);
         ext_irq_two_r <= fld(req.wdata, POS_LO);
      end
   end

   // register 15
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         calendar_r <= PRIO_RESET;
      end
      else if (wr_hit(req, OFS_PRIO_CTRL_15))
      begin
         calendar_r <= fld(req.wdata, POS_MID);
      end
   end

   // register 16
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         checksum_error_r <= PRIO_RESET;
         serial_b_error_r <= PRIO_RESET;
         serial_a_error_r <= PRIO_RESET;
      end
      else if (wr_hit(req, OFS_PRIO_CTRL_16))
      begin
         checksum_error_r <= fld(req.wdata, POS_HI);
         serial_b_error_r <= fld(req.wdata, POS_MID);
         serial_a_error_r <= fld(req.wdata, POS_LO);
      end
   end

   // register 18
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         voltage_detect_r <= PRIO_RESET;
      end
      else if (wr_hit(req, OFS_PRIO_CTRL_18))
      begin
         voltage_detect_r <= fld(req.wdata, POS_BOT);
      end
   end

   // register 19
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         charge_timer_r <= PRIO_RESET;
      end
      else if (wr_hit(req, OFS_PRIO_CTRL_19))
      begin
         charge_timer_r <= fld(req.wdata, POS_LO);
      end
   end

   // struct order follows the source numbering of the arbitration feed
   always_comb
   begin
      prio_r.pin_change_prio = pin_change_r;
      prio_r.comparator_prio = comparator_r;
      prio_r.i2c_master_event_prio = i2c_master_r;
      prio_r.i2c_slave_event_prio = i2c_slave_r;
      prio_r.ext_irq_one_prio = ext_irq_one_r;
      prio_r.serial_b_tx_prio = serial_b_tx_r;
      prio_r.serial_b_rx_prio = serial_b_rx_r;
      prio_r.ext_irq_two_prio = ext_irq_two_r;
      prio_r.calendar_prio = calendar_r;
      prio_r.checksum_error_prio = checksum_error_r;
      prio_r.serial_b_error_prio = serial_b_error_r;
      prio_r.serial_a_error_prio = serial_a_error_r;
      prio_r.voltage_detect_prio = voltage_detect_r;
      prio_r.charge_timer_prio = charge_timer_r;
   end

   // ----------------------------------------------------------------
   // read path: data stand one cycle after the read strobe
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] rd_word;

   always_comb
   begin
      rd_word = '0;
      case (req.addr)
         OFS_PRIO_CTRL_4:
         begin
            rd_word = place(prio_r.pin_change_prio, POS_HI);
            rd_word = rd_word | place(prio_r.comparator_prio, POS_MID);
            rd_word = rd_word | place(prio_r.i2c_master_event_prio, POS_LO);
            rd_word = rd_word | place(prio_r.i2c_slave_event_prio, POS_BOT);
         end

         OFS_PRIO_CTRL_5:
         begin
            rd_word = place(prio_r.ext_irq_one_prio, POS_BOT);
         end

         OFS_PRIO_CTRL_7:
         begin
            rd_word = place(prio_r.serial_b_tx_prio, POS_HI) | place(prio_r.serial_b_rx_prio, POS_MID);
            rd_word = rd_word | place(prio_r.ext_irq_two_prio, POS_LO);
         end

         OFS_PRIO_CTRL_15:
         begin
            rd_word = place(prio_r.calendar_prio, POS_MID);
         end

         OFS_PRIO_CTRL_16:
         begin
            rd_word = place(prio_r.checksum_error_prio, POS_HI) | place(prio_r.serial_b_error_prio, POS_MID);
            rd_word = rd_word | place(prio_r.serial_a_error_prio, POS_LO);
         end

         OFS_PRIO_CTRL_18:
         begin
            rd_word = place(prio_r.voltage_detect_prio, POS_BOT);
         end

         OFS_PRIO_CTRL_19:
         begin
            rd_word = place(prio_r.charge_timer_prio, POS_LO);
         end

         default:
         begin
            rd_word = '0;
         end
      endcase
   end

   // rdata is held at zero outside the answer cycle so stale values never leak
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rdata <= '0;
      end
      else if (req.rd)
      begin
         rdata <= rd_word;
      end
      else
      begin
         rdata <= '0;
      end
   end

   // ----------------------------------------------------------------
   // arbitration feed
   // ----------------------------------------------------------------
   logic [PRIO_W-1:0] prio_vec [NUM_SRC];

   // struct order is msb first, so source 0 is the pin change field
   always_comb
   begin
      for (int i = 0; i < NUM_SRC; i++)
      begin
         prio_vec[i] = prio_r[(NUM_SRC-1-i)*PRIO_W +: PRIO_W];
      end
   end

   assign prio = prio_r;

   always_comb
   begin
      for (int i = 0; i < NUM_SRC; i++)
      begin
         src_fwd[i] = src_req[i] && (prio_vec[i] != PRIO_OFF);
      end
   end

endmodule : interrupt_priority_fields

// ### pkg/prio_fields_pkg.sv
package prio_fields_pkg;

   // ----------------------------------------------------------------
   // register map (index = priority register number, word addressed)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int PRIO_W = 3;
   localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_4 = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_5 = 5'h05;
   localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_7 = 5'h07;
   localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_15 = 5'h0f;
   localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_16 = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_18 = 5'h12;
   localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_19 = 5'h13;

   // ----------------------------------------------------------------
   // field positions (low bit of each 3-bit field)
   // ----------------------------------------------------------------
   localparam int POS_HI = 12;
   localparam int POS_MID = 8;
   localparam int POS_LO = 4;
   localparam int POS_BOT = 0;

   // ----------------------------------------------------------------
   // codes and reset value
   // ----------------------------------------------------------------
   localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
   localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
   localparam logic [PRIO_W-1:0] PRIO_TOP = 3'h7;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [PRIO_W-1:0] pin_change_prio;
      logic [PRIO_W-1:0] comparator_prio;
      logic [PRIO_W-1:0] i2c_master_event_prio;
      logic [PRIO_W-1:0] i2c_slave_event_prio;
      logic [PRIO_W-1:0] ext_irq_one_prio;
      logic [PRIO_W-1:0] serial_b_tx_prio;
      logic [PRIO_W-1:0] serial_b_rx_prio;
      logic [PRIO_W-1:0] ext_irq_two_prio;
      logic [PRIO_W-1:0] calendar_prio;
      logic [PRIO_W-1:0] checksum_error_prio;
      logic [PRIO_W-1:0] serial_b_error_prio;
      logic [PRIO_W-1:0] serial_a_error_prio;
      logic [PRIO_W-1:0] voltage_detect_prio;
      logic [PRIO_W-1:0] charge_timer_prio;
   } prio_set_t;

   localparam int NUM_SRC = 14;

endpackage : prio_fields_pkg

// ### tb/interrupt_priority_fields_test.sv
`timescale 1ns/1ns
module interrupt_priority_fields_test;
   import prio_fields_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   reg_req_t req = '0;
   logic [NUM_SRC-1:0] pattern = 14'h3fff;
   logic [DATA_W-1:0] rdata;
   logic [NUM_SRC-1:0] src_req, src_fwd;
   prio_set_t prio;
   int err_count = 0;
   int checks = 0;
   logic [ADDR_W-1:0] map [7] = '{5'h04, 5'h05, 5'h07, 5'h0f, 5'h10, 5'h12, 5'h13};
   logic [DATA_W-1:0] img [7] = '{16'h4444, 16'h0004, 16'h4440, 16'h0400, 16'h4440, 16'h0004, 16'h0040};
   logic [DATA_W-1:0] pv [7] = '{16'h5, 16'h6, 16'h7, 16'h5, 16'h6, 16'h7, 16'h5};
   always #50 clk = ~clk;
   interrupt_priority_fields dut_u (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .src_req(src_req),
      .prio(prio), .src_fwd(src_fwd));
   src_model src_u (.clk(clk), .pattern(pattern), .src_req(src_req));
   task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask : wr
   task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      chk("rdata", rdata, exp);
      @(posedge clk);
   endtask : rd
   task summarize;
      if (err_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 7; i++)
         rd(map[i], img[i]);
      rd(5'h06, 16'h0000);
      // junk in unused bits must not stick
      for (int i = 0; i < 7; i++)
         wr(map[i], ((img[i] >> 2) * pv[i]) | ~((img[i] >> 2) * 16'h0007));
      for (int i = 0; i < 7; i++)
         rd(map[i], (img[i] >> 2) * pv[i]);
      chk("prio", prio, {{4{3'h5}}, 3'h6, {3{3'h7}}, 3'h5, {3{3'h6}}, 3'h7, 3'h5});
      chk("fwd", src_fwd, 14'h3fff);
      wr(OFS_PRIO_CTRL_4, 16'h0000);
      chk("fwd", src_fwd, 14'h3ff0);
      pattern <= 14'h2aaa;
      repeat (2) @(posedge clk);
      chk("fwd", src_fwd, 14'h2aa0);
      wr(5'h06, 16'hffff);
      wr(5'h1f, 16'hffff);
      chk("prio", prio, {12'h000, 3'h6, {3{3'h7}}, 3'h5, {3{3'h6}}, 3'h7, 3'h5});
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk("prio", prio, {NUM_SRC{PRIO_RESET}});
      rd(OFS_PRIO_CTRL_19, 16'h0040);
      summarize();
   end
   initial
   begin
      #100000;
      err_count++;
      summarize();
   end
endmodule : interrupt_priority_fields_test

// ### tb/prio_fields_checker.sv
`timescale 1ns/1ns
module prio_fields_checker
(
   input wire logic clk,
   input wire logic srst,
   input wire prio_fields_pkg::reg_req_t req,
   input wire logic [prio_fields_pkg::DATA_W-1:0] rdata,
   input wire logic [prio_fields_pkg::NUM_SRC-1:0] src_req,
   input wire prio_fields_pkg::prio_set_t prio,
   input wire logic [prio_fields_pkg::NUM_SRC-1:0] src_fwd
);
   import prio_fields_pkg::*;
   logic [NUM_SRC-1:0] live;
   // src_req bit 0 pairs with the struct's top field
   always_comb
   begin
      for (int i = 0; i < NUM_SRC; i++)
         live[i] = |prio[3*(NUM_SRC-1-i) +: 3];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_fwd_gated_req: assert property (src_fwd == (src_req & live)) else $error("forward mismatch");
   a_reset_all_four: assert property (disable iff (1'b0) srst |=> prio == {NUM_SRC{PRIO_RESET}})
      else $error("reset priority wrong");
   a_pin_change_write: assert property (req.wr && req.addr == OFS_PRIO_CTRL_4
      |=> prio.pin_change_prio == $past(req.wdata[14:12])) else $error("field 4 hi wrong");
   a_serial_a_write: assert property (req.wr && req.addr == OFS_PRIO_CTRL_16
      |=> prio.serial_a_error_prio == $past(req.wdata[6:4])) else $error("field 16 lo wrong");
   a_read_reg_19: assert property (req.rd && req.addr == OFS_PRIO_CTRL_19
      |=> rdata == {9'h000, $past(prio.charge_timer_prio), 4'h0}) else $error("read 19 wrong");
   a_read_reg_5: assert property (req.rd && req.addr == OFS_PRIO_CTRL_5
      |=> rdata == {13'h0000, $past(prio.ext_irq_one_prio)}) else $error("read 5 wrong");
   a_idle_read_zero: assert property (!req.rd |=> rdata == 16'h0000) else $error("rdata not idle");
   a_unmapped_ignored: assert property (req.wr && !(req.addr inside {5'h04, 5'h05, 5'h07, 5'h0f, 5'h10, 5'h12,
      5'h13}) |=> $stable(prio)) else $error("unmapped write took");
endmodule : prio_fields_checker
bind interrupt_priority_fields prio_fields_checker chk_u (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
   .src_req(src_req), .prio(prio), .src_fwd(src_fwd));

// ### tb/src_model.sv
`timescale 1ns/1ns
module src_model
(
   input wire logic clk,
   input wire logic [13:0] pattern,
   output logic [13:0] src_req
);
   // -----------------------------
   // level requests from sources
   // -----------------------------
   // sources change only on the system clock, as on chip
   always_ff @(posedge clk)
   begin
      src_req <= pattern;
   end
endmodule : src_model
